// ===== src/slg_level_cmp.sv
// Sign-magnitude PCM level compare against a high and a low threshold
`timescale 1ns/1ps
module slg_level_cmp #(
	parameter int W = 7
) (
	input  wire logic [W:0]   code,
	input  wire logic [W-1:0] hi_thresh,
	input  wire logic [W-1:0] lo_thresh,
	output logic              above_hi,
	output logic              below_lo
);
	// Sign bit is ignored; chord and step bits order as a magnitude
	assign above_hi = code[W-1:0] > hi_thresh;
	assign below_lo = code[W-1:0] < lo_thresh;
endmodule : slg_level_cmp

// ===== src/slg_pkg.sv
// Shared constants and types of the switched loss gain controller
package slg_pkg;

	// ----------------------------------------------------------------
	// Register offsets (byte addresses)
	// ----------------------------------------------------------------
	localparam logic [7:0] SLG_OFS_CTRL   = 8'h00;
	localparam logic [7:0] SLG_OFS_GAIN   = 8'h04;
	localparam logic [7:0] SLG_OFS_SPK    = 8'h08;
	localparam logic [7:0] SLG_OFS_THRESH = 8'h0C;
	localparam logic [7:0] SLG_OFS_STATUS = 8'h10;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int SLG_CTRL_EN_POS     = 0;
	localparam int SLG_CTRL_MODE_POS   = 1;
	localparam int SLG_CTRL_LOSS_POS   = 3;
	localparam int SLG_GAIN_TX_POS     = 0;
	localparam int SLG_GAIN_RX_POS     = 4;
	localparam int SLG_SPK_B0_POS      = 0;
	localparam int SLG_SPK_PLUS8_POS   = 3;
	localparam int SLG_THR_HI_POS      = 0;
	localparam int SLG_THR_LO_POS      = 8;
	localparam int SLG_STAT_LOSS_TX    = 0;
	localparam int SLG_STAT_LOSS_RX    = 1;
	localparam int SLG_STAT_CMP_LO     = 2;
	localparam int SLG_STAT_TXG_POS    = 8;
	localparam int SLG_STAT_RXG_POS    = 12;

	// ----------------------------------------------------------------
	// Reset values and gain figures
	// ----------------------------------------------------------------
	localparam logic [2:0] SLG_LOSS_RST     = 3'h4;
	localparam logic [1:0] SLG_MODE_RST     = 2'h0;
	localparam logic [3:0] SLG_GAIN_RST     = 4'h0;
	localparam logic [3:0] SLG_SPK_RST      = 4'h0;
	localparam logic [6:0] SLG_THR_HI_RST   = 7'h7F;
	localparam logic [6:0] SLG_THR_LO_RST   = 7'h00;
	localparam logic signed [4:0] SLG_GAIN_MIN = -5'sd8;
	localparam logic [4:0] SLG_SPK_STEP_DB  = 5'h02;
	localparam logic [4:0] SLG_SPK_PLUS8_DB = 5'h08;

	// ----------------------------------------------------------------
	// Modes and comparison states
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		SLG_MODE_TX_SQUELCH = 2'b00,
		SLG_MODE_RX_SQUELCH = 2'b01,
		SLG_MODE_GROUP      = 2'b10,
		SLG_MODE_TXRX       = 2'b11
	} slg_mode_type;

	typedef enum logic {
		SLG_CMP_HI = 1'b0,
		SLG_CMP_LO = 1'b1
	} slg_cmp_type;

	// ----------------------------------------------------------------
	// Carriers
	// ----------------------------------------------------------------
	typedef struct packed {
		logic       valid;
		logic [7:0] tx_code;
		logic [7:0] rx_code;
	} slg_sample_type;

	typedef struct packed {
		logic [3:0] tx_gain;
		logic [3:0] rx_gain;
		logic [4:0] spk_boost_db;
	} slg_gain_type;

endpackage : slg_pkg

// ===== src/slg_switched_loss.sv
// Switched loss controller with APB register access
// Operation
// - Group mode: tx above high moves loss to rx
// - Group mode: tx below low returns loss
// - Group mode: tx level alone picks lossy path
// - Speaker boost field, top bit adds 8 dB
// - Tx squelch: above high removes tx loss
// - Tx squelch: below low adds tx loss
// - Rx squelch: above high removes rx loss
// - Rx squelch: below low adds rx loss
// - Tx/rx mode: rx above high, loss tx
// - Tx/rx mode: rx below low, loss rx
// - Enable bit and two-bit mode select
// - Loss field 3 dB steps, resets 12 dB
// - Gain minus loss, clamp at -24 dB
// - Seven-bit thresholds, low not checked against high
`timescale 1ns/1ps
module slg_switched_loss (
	input  wire logic                   pclk,
	input  wire logic                   presetn,
	input  wire logic                   psel,
	input  wire logic                   penable,
	input  wire logic                   pwrite,
	input  wire logic [7:0]             paddr,
	input  wire logic [31:0]            pwdata,
	output logic [31:0]                 prdata,
	output logic                        pready,
	output logic                        pslverr,
	input  wire slg_pkg::slg_sample_type sample,
	output slg_pkg::slg_gain_type        gain_out
);
	import slg_pkg::*;

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	logic              enable_r,      enable_nxt;
	slg_mode_type      mode_r,        mode_nxt;
	logic [2:0]        loss_r,        loss_nxt;
	logic [3:0]        txg_r,         txg_nxt;
	logic [3:0]        rxg_r,         rxg_nxt;
	logic [3:0]        spk_r,         spk_nxt;
	logic [6:0]        thr_hi_r,      thr_hi_nxt;
	logic [6:0]        thr_lo_r,      thr_lo_nxt;
	slg_cmp_type       cmp_r,         cmp_nxt;
	logic              loss_tx_r,     loss_tx_nxt;
	logic              loss_rx_r,     loss_rx_nxt;
	slg_gain_type      gain_r,        gain_nxt;
	logic [31:0]       prdata_r,      prdata_nxt;
	logic              pready_r,      pready_nxt;
	logic              pslverr_r,     pslverr_nxt;

	logic [7:0]        mon_code;
	logic              above_hi;
	logic              below_lo;
	logic              wr_en;
	logic              addr_ok;
	logic [31:0]       rd_word;
	logic signed [4:0] tx_eff;
	logic signed [4:0] rx_eff;

	// ----------------------------------------------------------------
	// Level compare of the monitored path
	// ----------------------------------------------------------------
	// tx in tx squelch and group, rx otherwise
	always_comb begin
		if (mode_r == SLG_MODE_RX_SQUELCH || mode_r == SLG_MODE_TXRX) begin
			mon_code = sample.rx_code;
		end else begin
			mon_code = sample.tx_code;
		end
	end

	slg_level_cmp #(
		.W(7)
	) u_cmp (
		.code      (mon_code),
		.hi_thresh (thr_hi_r),
		.lo_thresh (thr_lo_r),
		.above_hi  (above_hi),
		.below_lo  (below_lo)
	);

	// ----------------------------------------------------------------
	// APB decode
	// ----------------------------------------------------------------
	always_comb begin
		addr_ok = 1'b1;
		rd_word = 32'h0000_0000;
		unique case (paddr)
			SLG_OFS_CTRL: begin
				rd_word[SLG_CTRL_EN_POS]                        = enable_r;
				rd_word[SLG_CTRL_MODE_POS +: 2]                 = mode_r;
				rd_word[SLG_CTRL_LOSS_POS +: 3]                 = loss_r;
			end
			SLG_OFS_GAIN: begin
				rd_word[SLG_GAIN_TX_POS +: 4]                   = txg_r;
				rd_word[SLG_GAIN_RX_POS +: 4]                   = rxg_r;
			end
			SLG_OFS_SPK: begin
				rd_word[SLG_SPK_B0_POS +: 4]                    = spk_r;
			end
			SLG_OFS_THRESH: begin
				rd_word[SLG_THR_HI_POS +: 7]                    = thr_hi_r;
				rd_word[SLG_THR_LO_POS +: 7]                    = thr_lo_r;
			end
			SLG_OFS_STATUS: begin
				rd_word[SLG_STAT_LOSS_TX]                       = loss_tx_r;
				rd_word[SLG_STAT_LOSS_RX]                       = loss_rx_r;
				rd_word[SLG_STAT_CMP_LO]                        = cmp_r;
				rd_word[SLG_STAT_TXG_POS +: 4]                  = gain_r.tx_gain;
				rd_word[SLG_STAT_RXG_POS +: 4]                  = gain_r.rx_gain;
			end
			default: begin
				addr_ok = 1'b0;
			end
		endcase
	end

	assign wr_en = psel && penable && pready_r && pwrite && addr_ok;

	// One-cycle answer: pready raised by the setup cycle
	always_comb begin
		pready_nxt  = 1'b0;
		prdata_nxt  = prdata_r;
		pslverr_nxt = 1'b0;
		if (psel && !penable) begin
			pready_nxt  = 1'b1;
			pslverr_nxt = !addr_ok;
			prdata_nxt  = pwrite ? 32'h0000_0000 : rd_word;
		end
	end

	// ----------------------------------------------------------------
	// Configuration registers
	// ----------------------------------------------------------------
	always_comb begin
		enable_nxt = enable_r;
		mode_nxt   = mode_r;
		loss_nxt   = loss_r;
		txg_nxt    = txg_r;
		rxg_nxt    = rxg_r;
		spk_nxt    = spk_r;
		thr_hi_nxt = thr_hi_r;
		thr_lo_nxt = thr_lo_r;
		if (wr_en) begin
			unique case (paddr)
				SLG_OFS_CTRL: begin
					enable_nxt = pwdata[SLG_CTRL_EN_POS];
					mode_nxt   = slg_mode_type'(pwdata[SLG_CTRL_MODE_POS +: 2]);
					loss_nxt   = pwdata[SLG_CTRL_LOSS_POS +: 3];
				end
				SLG_OFS_GAIN: begin
					txg_nxt = pwdata[SLG_GAIN_TX_POS +: 4];
					rxg_nxt = pwdata[SLG_GAIN_RX_POS +: 4];
				end
				SLG_OFS_SPK: begin
					spk_nxt = pwdata[SLG_SPK_B0_POS +: 4];
				end
				SLG_OFS_THRESH: begin
					thr_hi_nxt = pwdata[SLG_THR_HI_POS +: 7];
					thr_lo_nxt = pwdata[SLG_THR_LO_POS +: 7];
				end
				default: begin
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Hysteresis state and loss placement
	// ----------------------------------------------------------------
	always_comb begin
		cmp_nxt = cmp_r;
		if (!enable_r) begin
			cmp_nxt = SLG_CMP_HI;
		end else if (sample.valid) begin
			unique case (cmp_r)
				SLG_CMP_HI: begin
					if (above_hi) begin
						cmp_nxt = SLG_CMP_LO;
					end
				end
				SLG_CMP_LO: begin
					if (below_lo) begin
						cmp_nxt = SLG_CMP_HI;
					end
				end
			endcase
		end
	end

	always_comb begin
		loss_tx_nxt = 1'b0;
		loss_rx_nxt = 1'b0;
		if (enable_r) begin
			unique case (mode_nxt_sel(mode_r))
				SLG_MODE_TX_SQUELCH: begin
					loss_tx_nxt = (cmp_nxt == SLG_CMP_HI);
				end
				SLG_MODE_RX_SQUELCH: begin
					loss_rx_nxt = (cmp_nxt == SLG_CMP_HI);
				end
				SLG_MODE_GROUP: begin
					loss_tx_nxt = (cmp_nxt == SLG_CMP_HI);
					loss_rx_nxt = (cmp_nxt == SLG_CMP_LO);
				end
				SLG_MODE_TXRX: begin
					loss_tx_nxt = (cmp_nxt == SLG_CMP_LO);
					loss_rx_nxt = (cmp_nxt == SLG_CMP_HI);
				end
			endcase
		end
	end

	function automatic slg_mode_type mode_nxt_sel(input slg_mode_type m);
		mode_nxt_sel = m;
	endfunction : mode_nxt_sel

	// ----------------------------------------------------------------
	// Effective gains
	// ----------------------------------------------------------------
	always_comb begin
		tx_eff = 5'(signed'(txg_r)) - (loss_tx_nxt ? 5'(signed'({2'b00, loss_r})) : 5'sd0);
		rx_eff = 5'(signed'(rxg_r)) - (loss_rx_nxt ? 5'(signed'({2'b00, loss_r})) : 5'sd0);
		if (tx_eff < SLG_GAIN_MIN) begin
			tx_eff = SLG_GAIN_MIN;
		end
		if (rx_eff < SLG_GAIN_MIN) begin
			rx_eff = SLG_GAIN_MIN;
		end
		gain_nxt.tx_gain = tx_eff[3:0];
		gain_nxt.rx_gain = rx_eff[3:0];
		// speaker boost, plus 8 dB bit
		gain_nxt.spk_boost_db = 5'(spk_r[2:0] * SLG_SPK_STEP_DB)
			+ (spk_r[SLG_SPK_PLUS8_POS] ? SLG_SPK_PLUS8_DB : 5'h00);
	end

	// ----------------------------------------------------------------
	// State registers
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			enable_r  <= 1'b0;
			mode_r    <= slg_mode_type'(SLG_MODE_RST);
			loss_r    <= SLG_LOSS_RST;
			txg_r     <= SLG_GAIN_RST;
			rxg_r     <= SLG_GAIN_RST;
			spk_r     <= SLG_SPK_RST;
			thr_hi_r  <= SLG_THR_HI_RST;
			thr_lo_r  <= SLG_THR_LO_RST;
			cmp_r     <= SLG_CMP_HI;
			loss_tx_r <= 1'b0;
			loss_rx_r <= 1'b0;
			gain_r    <= '0;
			prdata_r  <= 32'h0000_0000;
			pready_r  <= 1'b0;
			pslverr_r <= 1'b0;
		end else begin
			enable_r  <= enable_nxt;
			mode_r    <= mode_nxt;
			loss_r    <= loss_nxt;
			txg_r     <= txg_nxt;
			rxg_r     <= rxg_nxt;
			spk_r     <= spk_nxt;
			thr_hi_r  <= thr_hi_nxt;
			thr_lo_r  <= thr_lo_nxt;
			cmp_r     <= cmp_nxt;
			loss_tx_r <= loss_tx_nxt;
			loss_rx_r <= loss_rx_nxt;
			gain_r    <= gain_nxt;
			prdata_r  <= prdata_nxt;
			pready_r  <= pready_nxt;
			pslverr_r <= pslverr_nxt;
		end
	end

	assign prdata   = prdata_r;
	assign pready   = pready_r;
	assign pslverr  = pslverr_r;
	assign gain_out = gain_r;

endmodule : slg_switched_loss

// ===== test/slg_codec_model.sv
// Sample stream source standing for the codec paths
`timescale 1ns/1ps
module slg_codec_model #(
	parameter int PERIOD = 2500
) (
	input wire logic             pclk,
	input wire logic             presetn,
	input wire logic [6:0]       tx_level,
	input wire logic [6:0]       rx_level,
	output slg_pkg::slg_sample_type sample
);
	import slg_pkg::*;
	int   cnt;
	logic sgn;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt <= 0;
			sgn <= 1'b0;
			sample <= '0;
		end else if (cnt == PERIOD - 1) begin
			cnt <= 0;
			sgn <= !sgn;
			sample <= {1'b1, sgn, tx_level, !sgn, rx_level};
		end else begin
			cnt <= cnt + 1;
			// Stale codes toggle between samples
			sample <= {1'b0, ~sample.tx_code, ~sample.rx_code};
		end
	end
endmodule : slg_codec_model

// ===== test/slg_switched_loss_assertions.sv
// Port-level checker of the switched loss controller
`timescale 1ns/1ps
module slg_checker (
	input wire logic                    pclk,
	input wire logic                    presetn,
	input wire logic                    psel,
	input wire logic                    penable,
	input wire logic                    pwrite,
	input wire logic [7:0]              paddr,
	input wire logic [31:0]             pwdata,
	input wire logic [31:0]             prdata,
	input wire logic                    pready,
	input wire logic                    pslverr,
	input wire slg_pkg::slg_sample_type sample,
	input wire slg_pkg::slg_gain_type   gain_out
);
	import slg_pkg::*;
	// ----------------------------------------------------------------
	// Shadow of the configuration written over the bus
	// ----------------------------------------------------------------
	logic       wr;
	logic [5:0] ctrl_s;
	logic [7:0] gain_s;
	logic [3:0] spk_s;
	assign wr = psel && penable && pready && pwrite;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_s <= 6'h20;
			gain_s <= 8'h00;
			spk_s <= 4'h0;
		end else if (wr && paddr == 8'h00) begin
			ctrl_s <= pwdata[5:0];
		end else if (wr && paddr == 8'h04) begin
			gain_s <= pwdata[7:0];
		end else if (wr && paddr == 8'h08) begin
			spk_s <= pwdata[3:0];
		end
	end
	function automatic logic [3:0] att(input logic [3:0] g, input logic [2:0] l);
		logic signed [5:0] d;
		d = $signed({{2{g[3]}}, g}) - $signed({3'h0, l});
		att = (d < -6'sd8) ? 4'h8 : d[3:0];
	endfunction : att
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	chk_ready_next: assert property (psel && !penable |=> pready)
		else $error("pready missing after setup");
	chk_ready_pulse: assert property (pready |=> !pready)
		else $error("pready longer than one cycle");
	chk_err_unmapped: assert property (psel && !penable && paddr > 8'h10 |=> pslverr && prdata == 32'h0)
		else $error("no error on unmapped address");
	chk_spk_boost: assert property (!$past(wr) |->
		gain_out.spk_boost_db == {1'b0, spk_s[2:0], 1'b0} + (spk_s[3] ? 5'h08 : 5'h00))
		else $error("speaker boost wrong");
	chk_off_gains: assert property (!ctrl_s[0] && !$past(wr) |->
		gain_out.tx_gain == gain_s[3:0] && gain_out.rx_gain == gain_s[7:4])
		else $error("gains altered while disabled");
	chk_txsq_rx: assert property (ctrl_s[2:0] == 3'b001 && !$past(wr) |-> gain_out.rx_gain == gain_s[7:4])
		else $error("rx gain altered in tx squelch");
	chk_rxsq_tx: assert property (ctrl_s[2:0] == 3'b011 && !$past(wr) |-> gain_out.tx_gain == gain_s[3:0])
		else $error("tx gain altered in rx squelch");
	chk_loss_clamp: assert property (ctrl_s[0] && !$past(wr) |->
		(gain_out.tx_gain == gain_s[3:0] || gain_out.tx_gain == att(gain_s[3:0], ctrl_s[5:3])) &&
		(gain_out.rx_gain == gain_s[7:4] || gain_out.rx_gain == att(gain_s[7:4], ctrl_s[5:3])))
		else $error("gain not programmed or clamped loss");
	chk_gain_cause: assert property ($changed(gain_out) |-> $past(sample.valid) || $past(wr) || $past(wr, 2))
		else $error("gain changed without sample or write");
endmodule : slg_checker
bind slg_switched_loss slg_checker i_slg_checker (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.sample(sample), .gain_out(gain_out));

// ===== test/slg_switched_loss_tb_top.sv
// Self-checking bench of the switched loss controller
`timescale 1ns/1ps
module slg_switched_loss_tb_top;
	import slg_pkg::*;
	logic           pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
	logic [7:0]     paddr;
	logic [31:0]    pwdata, prdata, rd;
	logic [6:0]     tx_level, rx_level;
	slg_sample_type sample;
	slg_gain_type   gain_out;
	int             num_errors, cmp_count;
	int             cycles = 0;
	slg_switched_loss i_slg_switched_loss (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.sample(sample), .gain_out(gain_out));
	slg_codec_model #(.PERIOD(16)) i_slg_codec_model (.pclk(pclk), .presetn(presetn), .tx_level(tx_level),
		.rx_level(rx_level), .sample(sample));
	initial begin
		pclk = 1'b0;
		forever #25 pclk = ~pclk;
	end
	// ----------------------------------------------------------------
	// Shared tasks
	// ----------------------------------------------------------------
	task automatic summarize();
		$display("Comparisons %0d, mismatches %0d", cmp_count, num_errors);
		if (num_errors == 0 && cmp_count > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : summarize
	task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
		cmp_count++;
		if (got !== exp) begin
			num_errors++;
			$display("[FAIL] %s expected %h seen %h", name, exp, got);
		end
	endtask : check
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 40);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		check("pready", 32'h1, {31'h0, pready});
	endtask : apb
	task automatic wait_sample();
		int n;
		n = 0;
		repeat (2) begin
			do begin
				@(posedge pclk);
				n++;
			end while (sample.valid !== 1'b1 && n < 80);
		end
		#1;
	endtask : wait_sample
	task automatic set_level(input logic [1:0] m, input logic [6:0] l);
		logic [6:0] o;
		o = (l > 7'h40) ? 7'h08 : 7'h7F;
		@(posedge pclk);
		tx_level <= m[0] ? o : l;
		rx_level <= m[0] ? l : o;
	endtask : set_level
	task automatic expect_place(input logic [1:0] pl, input logic c);
		logic [3:0] tx_e, rx_e;
		tx_e = pl[1] ? 4'hB : 4'h2;
		rx_e = pl[0] ? 4'h8 : 4'hC;
		check("tx_gain", {28'h0, tx_e}, {28'h0, gain_out.tx_gain});
		check("rx_gain", {28'h0, rx_e}, {28'h0, gain_out.rx_gain});
		apb(1'b0, SLG_OFS_STATUS, 32'h0);
		check("status", {16'h0, rx_e, tx_e, 5'h0, c, pl[0], pl[1]}, rd & 32'h0000FF07);
	endtask : expect_place
	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic t_regs();
		check("gain_out", 32'h0, {19'h0, gain_out});
		apb(1'b0, SLG_OFS_CTRL, 32'h0);
		check("ctrl", 32'h20, rd);
		apb(1'b0, SLG_OFS_THRESH, 32'h0);
		check("thresh", 32'h7F, rd);
		apb(1'b1, SLG_OFS_STATUS, 32'hFFFF);
		apb(1'b0, SLG_OFS_STATUS, 32'h0);
		check("status", 32'h0, rd);
		check("status_err", 32'h0, {31'h0, err});
		apb(1'b1, 8'h14, 32'h1);
		check("wr_err", 32'h1, {31'h0, err});
		apb(1'b0, 8'h14, 32'h0);
		check("rd_err", 32'h1, {31'h0, err});
		check("rd_data", 32'h0, rd);
	endtask : t_regs
	task automatic t_spk();
		for (int i = 0; i < 16; i++) begin
			apb(1'b1, SLG_OFS_SPK, i);
			@(posedge pclk);
			#1;
			check("spk_boost_db", (i % 8) * 2 + (i / 8) * 8, {27'h0, gain_out.spk_boost_db});
		end
	endtask : t_spk
	task automatic t_mode(input logic [1:0] m, input logic [1:0] hi_pl, input logic [1:0] lo_pl);
		apb(1'b1, SLG_OFS_CTRL, 32'h38);
		set_level(m, 7'h10);
		apb(1'b1, SLG_OFS_CTRL, {26'h0, 3'h7, m, 1'b1});
		wait_sample();
		expect_place(hi_pl, 1'b0);
		set_level(m, 7'h50);
		wait_sample();
		expect_place(lo_pl, 1'b1);
		set_level(m, 7'h30);
		wait_sample();
		expect_place(lo_pl, 1'b1);
		apb(1'b1, SLG_OFS_CTRL, 32'h38);
		apb(1'b1, SLG_OFS_CTRL, {26'h0, 3'h7, m, 1'b1});
		wait_sample();
		expect_place(hi_pl, 1'b0);
		set_level(m, 7'h10);
		wait_sample();
		expect_place(hi_pl, 1'b0);
		apb(1'b1, SLG_OFS_CTRL, 32'h38);
		wait_sample();
		expect_place(2'b00, 1'b0);
	endtask : t_mode
	task automatic t_reset();
		@(posedge pclk);
		presetn <= 1'b0;
		repeat (3) @(posedge pclk);
		#1;
		check("gain_rst", 32'h0, {19'h0, gain_out});
		check("prdata_rst", 32'h0, prdata);
		check("ready_rst", 32'h0, {30'h0, pready, pslverr});
		@(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, SLG_OFS_CTRL, 32'h0);
		check("ctrl_rst", 32'h20, rd);
		apb(1'b0, SLG_OFS_THRESH, 32'h0);
		check("thresh_rst", 32'h7F, rd);
	endtask : t_reset
	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		tx_level = 7'h00;
		rx_level = 7'h00;
		num_errors = 0;
		cmp_count = 0;
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		t_regs();
		t_spk();
		apb(1'b1, SLG_OFS_GAIN, 32'hC2);
		apb(1'b1, SLG_OFS_THRESH, 32'h2040);
		t_mode(2'b00, 2'b10, 2'b00);
		t_mode(2'b01, 2'b01, 2'b00);
		t_mode(2'b10, 2'b10, 2'b01);
		t_mode(2'b11, 2'b01, 2'b10);
		t_reset();
		summarize();
	end
	always @(posedge pclk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			num_errors++;
			summarize();
		end
	end
endmodule : slg_switched_loss_tb_top
